// >>> hw/srfc_map.svh
// Register map, field positions, reset values and answer codes of the receive frame block.
// Assumes a 32-bit AXI4-Lite slave port with word-aligned byte addresses.
`ifndef SRFC_MAP_SVH
`define SRFC_MAP_SVH
// Byte offsets
`define SRFC_OFS_RFC     8'h00
`define SRFC_OFS_CTRL    8'h04
`define SRFC_OFS_STAT    8'h08
`define SRFC_OFS_DATA    8'h0c
// Writable bits of the frame control register
`define SRFC_RFC_WMASK   32'hffff7ff0
`define SRFC_RFC_RESET   32'h00000000
// Control and status bit positions
`define SRFC_CTRL_EN     0
`define SRFC_STAT_BUSY   0
`define SRFC_STAT_AVAIL  1
`define SRFC_STAT_OVR    2
`define SRFC_STAT_PH2    3
// Answers
`define SRFC_RESP_OKAY   2'h0
`define SRFC_RESP_SLVERR 2'h2
`endif

// >>> hw/srfc_pkg.sv
// Types shared by the receive frame block.
// Assumes the map header supplies every numeric constant.
package srfc_pkg;
  // Frame control register layout, bit 31 first
  typedef struct packed {
    logic       phase_dual;  // Dual-phase frame
    logic [6:0] len2;        // Phase-2 words minus one
    logic [2:0] wsz2;        // Phase-2 word size code
    logic [1:0] xmode;       // Expansion and bit order
    logic       sync_ign;    // Extra sync ignore
    logic [1:0] dly;         // First bit delay
    logic       rsv15;       // Reserved
    logic [6:0] len1;        // Phase-1 words minus one
    logic [2:0] wsz1;        // Phase-1 word size code
    logic       rev;         // 32-bit reverse enable
    logic [3:0] rsv;         // Reserved
  } srfc_ctl_t;
  // Receive sequencer states
  typedef enum logic [1:0] {SRFC_IDLE, SRFC_DELAY, SRFC_DATA} srfc_state_t;
  // Link pins after synchronisation
  typedef struct packed {
    logic bclk;
    logic fsync;
    logic din;
  } srfc_link_t;
endpackage

// >>> hw/srfc_rx_frame.sv
// Receive frame parser with AXI4-Lite registers and a two-entry word buffer.
// Assumes bit clock, frame sync and data come from an external source, far slower
// than CLOCK; data and sync are sampled on the rising bit clock edge.
`include "srfc_map.svh"
module srfc_rx_frame (
  // System
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  // AXI4-Lite write address and data
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // AXI4-Lite write response
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // AXI4-Lite read
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // Serial link
  input  wire logic        RX_BCLK,
  input  wire logic        RX_FSYNC,
  input  wire logic        RX_DIN
);
  //////////////////////////////////////////////////////////////////////////////
  // Functions

  // Bits per word for a size code; reserved codes fall back to 8
  function automatic logic [5:0] size_bits(input logic [2:0] c);
    case (c)
      3'h0:    size_bits = 6'h08;
      3'h1:    size_bits = 6'h0c;
      3'h2:    size_bits = 6'h10;
      3'h3:    size_bits = 6'h14;
      3'h4:    size_bits = 6'h18;
      3'h5:    size_bits = 6'h20;
      default: size_bits = 6'h08;
    endcase
  endfunction

  // Mu-law code to 16-bit linear sample
  function automatic logic [15:0] mu_expand(input logic [7:0] c);
    logic [7:0]  x;
    logic [15:0] t;
    x = ~c;
    t = ({9'h000, x[3:0], 3'h0} + 16'h0084) << x[6:4];
    mu_expand = x[7] ? 16'h0084 - t : t - 16'h0084;
  endfunction

  // A-law code to 16-bit linear sample
  function automatic logic [15:0] a_expand(input logic [7:0] c);
    logic [7:0]  x;
    logic [15:0] t;
    x = c ^ 8'h55;
    t = {8'h00, x[3:0], 4'h0};
    if (x[6:4] == 3'h0)
      t = t + 16'h0008;
    else
      t = (t + 16'h0108) << (x[6:4] - 3'h1);
    a_expand = x[7] ? t : 16'h0000 - t;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state

  srfc_pkg::srfc_ctl_t   ctl_q;        // Frame control register
  logic                  en_q;         // Receiver enable
  logic                  ovr_q;        // Word lost to a full buffer
  srfc_pkg::srfc_link_t  s1_q;         // First synchroniser stage
  srfc_pkg::srfc_link_t  s2_q;         // Second synchroniser stage
  logic                  bclk_old_q;   // Previous bit clock level
  logic                  fs_old_q;     // Sync level at previous bit edge
  srfc_pkg::srfc_state_t st_q, st_d;   // Sequencer state
  logic                  ph2_q, ph2_d; // In phase 2
  logic [6:0]            wcnt_q, wcnt_d; // Words done in this phase
  logic [5:0]            bcnt_q, bcnt_d; // Bits done in this word
  logic [1:0]            dcnt_q, dcnt_d; // Delay bits left
  logic [31:0]           sr_q, sr_d;   // Shift register
  logic [31:0]           mem [2];      // Word buffer
  logic                  wp_q, rp_q;   // Buffer pointers
  logic [1:0]            cnt_q;        // Buffer fill
  logic                  aw_q, w_q;    // Write address and data held
  logic [7:0]            awa_q;        // Held write address
  logic [31:0]           wd_q;         // Held write data

  //////////////////////////////////////////////////////////////////////////////
  // Link synchroniser and bit clock edge

  // Two flip-flops per pin; only stage two feeds logic
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s1_q       <= '0;
      s2_q       <= '0;
      bclk_old_q <= 1'b0;
    end
    else
    begin
      s1_q       <= '{RX_BCLK, RX_FSYNC, RX_DIN};
      s2_q       <= s1_q;
      bclk_old_q <= s2_q.bclk;
    end
  end

  wire bit_en  = s2_q.bclk & ~bclk_old_q;          // Rising bit clock
  wire fs_rise = bit_en & s2_q.fsync & ~fs_old_q;  // New sync pulse

  //////////////////////////////////////////////////////////////////////////////
  // Frame sequencer decode

  wire       busy     = st_q != srfc_pkg::SRFC_IDLE;
  wire       sync_go  = fs_rise & en_q & (~busy | ~ctl_q.sync_ign);
  // Phase of the bit now taken; a sync restarts in phase 1. Reading ph2_d here would loop.
  wire       cur_ph2  = ph2_q & ~sync_go;
  wire [2:0] cur_wsz  = cur_ph2 ? ctl_q.wsz2 : ctl_q.wsz1;
  wire [5:0] wbits    = size_bits(cur_wsz);
  wire       w8       = cur_wsz == 3'h0;
  wire [1:0] mode     = w8 ? ctl_q.xmode : 2'h0;
  wire       rev32    = ctl_q.rev & (wbits == 6'h20);
  wire       lsb_in   = (mode == 2'h1) | rev32;
  wire [1:0] dly_code = (ctl_q.dly == 2'h3) ? 2'h2 : ctl_q.dly;
  wire [6:0] last_w   = cur_ph2 ? ctl_q.len2 : ctl_q.len1;
  wire [31:0] wmask   = 32'hffffffff >> (6'h20 - wbits); // Drops bits of older words
  wire [31:0] lsb_val = sr_d >> (6'h20 - wbits);
  wire [31:0] raw_val = lsb_in ? lsb_val : (sr_d & wmask);

  logic       take;     // Current bit belongs to the word
  logic       done;     // Word complete this bit
  logic [31:0] word;    // Formatted word

  // Next-state logic for the sequencer, evaluated at each bit edge
  always_comb
  begin
    st_d   = st_q;
    ph2_d  = ph2_q;
    wcnt_d = wcnt_q;
    bcnt_d = bcnt_q;
    dcnt_d = dcnt_q;
    sr_d   = sr_q;
    take   = 1'b0;
    done   = 1'b0;
    if (!en_q)
      st_d = srfc_pkg::SRFC_IDLE;
    else if (bit_en)
    begin
      if (sync_go)
      begin
        // A fresh frame, or a restart of the current one
        ph2_d  = 1'b0;
        wcnt_d = 7'h00;
        bcnt_d = 6'h00;
        sr_d   = 32'h0;
        dcnt_d = dly_code;
        take   = dly_code == 2'h0;
        st_d   = take ? srfc_pkg::SRFC_DATA : srfc_pkg::SRFC_DELAY;
      end
      else if (st_q == srfc_pkg::SRFC_DELAY)
      begin
        dcnt_d = dcnt_q - 2'h1;
        take   = dcnt_q == 2'h1;
        if (take)
          st_d = srfc_pkg::SRFC_DATA;
      end
      else if (st_q == srfc_pkg::SRFC_DATA)
        take = 1'b1;
    end
    if (take)
    begin
      // Shift at the top when bits arrive LSB first
      sr_d   = lsb_in ? {s2_q.din, sr_d[31:1]} : {sr_d[30:0], s2_q.din};
      bcnt_d = bcnt_d + 6'h01;
      if (bcnt_d == wbits)
      begin
        done   = 1'b1;
        bcnt_d = 6'h00;
        if (wcnt_d == last_w)
        begin
          wcnt_d = 7'h00;
          if (!ph2_d && ctl_q.phase_dual)
            ph2_d = 1'b1;
          else
          begin
            // Frame complete; the phase flag returns with the idle state
            st_d  = srfc_pkg::SRFC_IDLE;
            ph2_d = 1'b0;
          end
        end
        else
          wcnt_d = wcnt_d + 7'h01;
      end
    end
  end

  // Word formatting: expansion applies only to 8-bit words
  always_comb
  begin
    case (mode)
      2'h2:    word = {16'h0, mu_expand(sr_d[7:0])};
      2'h3:    word = {16'h0, a_expand(sr_d[7:0])};
      default: word = raw_val;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q   <= srfc_pkg::SRFC_IDLE;
      ph2_q  <= 1'b0;
      wcnt_q <= 7'h00;
      bcnt_q <= 6'h00;
      dcnt_q <= 2'h0;
      sr_q   <= 32'h0;
    end
    else
    begin
      st_q   <= st_d;
      ph2_q  <= ph2_d;
      wcnt_q <= wcnt_d;
      bcnt_q <= bcnt_d;
      dcnt_q <= dcnt_d;
      sr_q   <= sr_d;
    end
  end

  // Sync level is remembered only at bit edges so a long pulse counts once
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      fs_old_q <= 1'b0;
    else if (bit_en)
      fs_old_q <= s2_q.fsync;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; the link cannot be stalled, so a full buffer drops the word

  wire in_ready = cnt_q != 2'h2;
  wire push     = done & in_ready;
  wire out_vld  = cnt_q != 2'h0;
  logic pop;

  // Buffer pointers and fill count
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data array needs no reset; the fill count guards it
  always_ff @(posedge CLOCK)
  begin
    if (push)
      mem[wp_q] <= word;
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign AWREADY = ~aw_q & ~BVALID;
  assign WREADY  = ~w_q & ~BVALID;
  wire   wr_go   = aw_q & w_q & ~BVALID;
  wire   wr_rfc  = wr_go & (awa_q == `SRFC_OFS_RFC);
  wire   wr_ctrl = wr_go & (awa_q == `SRFC_OFS_CTRL);
  wire   wr_stat = wr_go & (awa_q == `SRFC_OFS_STAT);
  wire   wr_ok   = wr_rfc | wr_ctrl | wr_stat;
  logic  [3:0] wstrb_q; // Held byte enables
  wire [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] rfc_mask = bmask & `SRFC_RFC_WMASK;
  wire   ovr_clr = wr_stat & bmask[`SRFC_STAT_OVR] & wd_q[`SRFC_STAT_OVR];

  // Capture address and data in either order, then answer
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      awa_q  <= 8'h00;
      wd_q   <= 32'h0;
      wstrb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP  <= `SRFC_RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_q  <= 1'b1;
        awa_q <= {AWADDR[7:2], 2'b00};
      end
      if (WVALID && WREADY)
      begin
        w_q  <= 1'b1;
        wd_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_go)
      begin
        aw_q   <= 1'b0;
        w_q    <= 1'b0;
        BVALID <= 1'b1;
        BRESP  <= wr_ok ? `SRFC_RESP_OKAY : `SRFC_RESP_SLVERR;
      end
      else if (BREADY)
        BVALID <= 1'b0;
    end
  end

  // Software-visible control state
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctl_q <= `SRFC_RFC_RESET;
      en_q  <= 1'b0;
      ovr_q <= 1'b0;
    end
    else
    begin
      if (wr_rfc)
        ctl_q <= (ctl_q & ~rfc_mask) | (wd_q & rfc_mask);
      if (wr_ctrl && bmask[`SRFC_CTRL_EN])
        en_q <= wd_q[`SRFC_CTRL_EN];
      // A lost word in the clearing cycle keeps the flag set
      if (done && !in_ready)
        ovr_q <= 1'b1;
      else if (ovr_clr)
        ovr_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign ARREADY = ~RVALID;
  wire   rd_go   = ARVALID & ARREADY;
  wire [7:0] ra  = {ARADDR[7:2], 2'b00};
  wire [31:0] stat_val = {28'h0, ph2_q, ovr_q, out_vld, busy};
  assign pop = rd_go & (ra == `SRFC_OFS_DATA) & out_vld;

  // Read answer one cycle after the address is taken; data reads pop the buffer
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0;
      RRESP  <= `SRFC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      RVALID <= 1'b1;
      RRESP  <= `SRFC_RESP_OKAY;
      if (ra == `SRFC_OFS_RFC)
        RDATA <= ctl_q & `SRFC_RFC_WMASK;
      else if (ra == `SRFC_OFS_CTRL)
        RDATA <= {31'h0, en_q};
      else if (ra == `SRFC_OFS_STAT)
        RDATA <= stat_val;
      else if (ra == `SRFC_OFS_DATA)
        RDATA <= out_vld ? mem[rp_q] : 32'h0;
      else
      begin
        RDATA <= 32'h0;
        RRESP <= `SRFC_RESP_SLVERR;
      end
    end
    else if (RREADY)
      RVALID <= 1'b0;
  end
endmodule

// >>> verification/serial_receive_frame_config_test.sv
// Bench for the receive frame block: registers, frame parsing, word buffer.
// Assumes srfc_codec as far side and the checker bound to the design.
`include "srfc_map.svh"
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module serial_receive_frame_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK, RESET_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, RX_BCLK, RX_FSYNC, RX_DIN;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, seed;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [33:0] expq [$];  // Expected {resp, data}, oldest first
  logic [33:0] want;
  int          err_count = 0, samples_checked = 0, cycles = 0;
  int          sizes [6] = '{8, 12, 16, 20, 24, 32};
  ////////////////////////////////////////////////////////////////
  srfc_rx_frame DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .RX_BCLK(RX_BCLK),
    .RX_FSYNC(RX_FSYNC), .RX_DIN(RX_DIN));
  srfc_codec u_codec (.bclk(RX_BCLK), .fsync(RX_FSYNC), .din(RX_DIN));
  initial
  begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // Every answer is matched against the oldest note
  always @(posedge CLOCK)
  begin
    if (RESET_N && ((RVALID && RREADY) || (BVALID && BREADY)))
    begin
      want = expq.pop_front();
      `CHK(RVALID ? {RRESP, RDATA} : {BRESP, 32'h0}, want)
    end
  end
  // Hang guard, well above the longest expected run
  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ah, wh, bh;
    expq.push_back({r, 32'h0});
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(negedge CLOCK);
      ah = AWVALID && AWREADY;
      wh = WVALID && WREADY;
      bh = BVALID;
      @(posedge CLOCK);
      if (ah) AWVALID <= 1'b0;
      if (wh) WVALID <= 1'b0;
    end while (!bh);
    BREADY <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    logic ah, vh;
    expq.push_back({r, e});
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(negedge CLOCK);
      ah = ARVALID && ARREADY;
      vh = RVALID;
      @(posedge CLOCK);
      if (ah) ARVALID <= 1'b0;
    end while (!vh);
    RREADY <= 1'b0;
    @(posedge CLOCK);
  endtask
  // Reconfigure only with the receiver held off, then run one frame
  task automatic frame(input srfc_pkg::srfc_ctl_t c, input logic [63:0] b,
                       input logic [63:0] f, input int n);
    wr(`SRFC_OFS_CTRL, 32'h0, 2'h0);
    wr(`SRFC_OFS_RFC, c, 2'h0);
    wr(`SRFC_OFS_CTRL, 32'h1, 2'h0);
    u_codec.send(b, f, n);
    repeat (8) @(posedge CLOCK);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    srfc_pkg::srfc_ctl_t c;
    logic [31:0] w, x;
    logic [7:0]  r8;  // Byte in reversed bit order
    int d, n;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hf;
    RESET_N = 1'b0;
    seed = 32'h0a67ac3e;
    repeat (20) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    rd(`SRFC_OFS_RFC, 32'h0);
    rd(8'h40, 32'h0, `SRFC_RESP_SLVERR);
    wr(8'h40, 32'hffffffff, `SRFC_RESP_SLVERR);
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(`SRFC_OFS_RFC, seed, 2'h0);
      rd(`SRFC_OFS_RFC, seed & 32'hffff7ff0);
    end
    // Every size code in both phases, delays 0 to 2, modes ignored off 8 bits
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      x = lfsr(seed);
      w = seed >> (32 - sizes[k]);
      x = x >> (32 - sizes[5 - k]);
      d = k % 3;
      n = d + sizes[k] + sizes[5 - k];
      c = '0;
      c.phase_dual = 1'b1;
      c.wsz1 = 3'(k);
      c.wsz2 = 3'(5 - k);
      c.dly = 2'(d);
      c.xmode = (k > 0 && k < 4) ? 2'(k) : 2'h0;
      frame(c, (64'(seed) << (n - d)) | (64'(w) << sizes[5 - k]) | 64'(x),
            64'h1 << (n - 1), n);
      rd(`SRFC_OFS_DATA, w);
      rd(`SRFC_OFS_DATA, x);
    end
    // One word per phase; LSB first only in the 8-bit phase; extra bits dropped
    c = '0;
    c.phase_dual = 1'b1;
    c.wsz2 = 3'h1;
    c.xmode = 2'h1;
    seed = lfsr(seed);
    frame(c, 64'(seed[27:0]), 64'h1 << 27, 28);
    r8 = {<<{seed[27:20]}};
    rd(`SRFC_OFS_STAT, 32'h2);
    rd(`SRFC_OFS_DATA, 32'(r8));
    rd(`SRFC_OFS_DATA, 32'(seed[19:8]));
    rd(`SRFC_OFS_DATA, 32'h0);
    // Expansion of 8-bit words
    c.phase_dual = 1'b0;
    c.wsz2 = 3'h0;
    c.xmode = 2'h2;
    frame(c, 64'h80, 64'h80, 8);
    rd(`SRFC_OFS_DATA, 32'h00007d7c);
    c.xmode = 2'h3;
    frame(c, 64'h55, 64'h80, 8);
    rd(`SRFC_OFS_DATA, 32'h0000fff8);
    // 32-bit word taken LSB first
    c.xmode = 2'h1;
    c.wsz1 = 3'h5;
    c.rev = 1'b1;
    seed = lfsr(seed);
    frame(c, 64'(seed), 64'h80000000, 32);
    w = {<<{seed}};
    rd(`SRFC_OFS_DATA, w);
    // Three words into two places: overrun, drain, clear
    c = '0;
    c.len1 = 7'h2;
    seed = lfsr(seed);
    frame(c, 64'(seed[23:0]), 64'h800000, 24);
    rd(`SRFC_OFS_STAT, 32'h6);
    rd(`SRFC_OFS_DATA, 32'(seed[23:16]));
    rd(`SRFC_OFS_DATA, 32'(seed[15:8]));
    rd(`SRFC_OFS_DATA, 32'h0);
    wr(`SRFC_OFS_STAT, 32'h4, 2'h0);
    rd(`SRFC_OFS_STAT, 32'h0);
    // Second sync inside the first word, disregarded or restarting
    for (int g = 0; g < 2; g++)
    begin
      c = '0;
      c.len1 = 7'h1;
      c.dly = 2'h1;
      c.sync_ign = 1'(g);
      seed = lfsr(seed);
      frame(c, 64'(seed[21:0]), (64'h1 << 21) | (64'h1 << 16), 22);
      rd(`SRFC_OFS_DATA, 32'(g ? seed[20:13] : seed[15:8]));
      rd(`SRFC_OFS_DATA, 32'(g ? seed[12:5] : seed[7:0]));
    end
    wrap_up();
  end
endmodule

// >>> verification/srfc_codec.sv
// Far-side serial source: bit clock, frame sync and data for one frame.
// Assumes the bench calls send(); the bit clock stands still between frames.
module srfc_codec (
  // Serial link
  output logic bclk,
  output logic fsync,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;  // Inside a frame
  initial
  begin
    bclk = 1'b0;
    fsync = 1'b0;
    din = 1'b0;
  end
  // Released data toggles, so a stale bit never passes for a driven one
  always #100 if (!busy) din = ~din;
  // Element n-1 goes first; data moves while the bit clock is low
  task automatic send(input logic [63:0] b, input logic [63:0] f, input int n);
    busy = 1'b1;
    #37;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = b[i];
      fsync = f[i];
      #400 bclk = 1'b1;
      #400 bclk = 1'b0;
    end
    fsync = 1'b0;
    busy = 1'b0;
  endtask
endmodule

// >>> verification/srfc_rx_frame_assertions.sv
// Checker: bus handshakes and reserved bits of the receive frame block.
// Assumes it is bound to srfc_rx_frame and sees only its ports.
`include "srfc_map.svh"
module srfc_rx_chk (
  // System
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  // Write channels
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  // Read channels
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////////////////////////////
  // Request steps
  sequence s_wr_taken; AWVALID && AWREADY && WVALID && WREADY; endsequence
  sequence s_rd_taken; ARVALID && ARREADY; endsequence
  sequence s_rd_ctl; s_rd_taken ##0 ARADDR[7:2] == 6'h00; endsequence
  sequence s_rd_bad; s_rd_taken ##0 ARADDR >= 8'h10; endsequence
  // Both halves at one edge: capture edge, then write edge
  property p_wr_answer; s_wr_taken |-> ##2 BVALID; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  // A pending answer must not move before it is taken
  property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // No new write while the answer is pending
  property p_b_block; BVALID |-> !AWREADY && !WREADY; endproperty
  a_b_block: assert property (p_b_block) else $error("write accepted early");
  // Read address refused only while a read answer waits
  property p_ar_block; ARREADY != RVALID; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read ready wrong");
  property p_rd_answer; s_rd_taken |=> RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // Reserved control bits never show ones
  property p_rsv_zero; s_rd_ctl |=> RDATA[15] == 1'b0 && RDATA[3:0] == 4'h0; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
  property p_bad_addr; s_rd_bad |=> RRESP == `SRFC_RESP_SLVERR && RDATA == 32'h0; endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped read wrong");
endmodule
////////////////////////////////////////////////////////////////
bind srfc_rx_frame srfc_rx_chk u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
  .RDATA(RDATA), .RRESP(RRESP));
